// >>> rtl/tdi_pkg.sv
// constants and types shared by the time de-interleaver files
package tdi_pkg;
  localparam int CELL_W = 24;             // one complex cell, I and Q
  localparam int AW = 12;                 // memory address width
  localparam int SW = 13;                 // width of sizes and positions (up to MEM_DEPTH)
  localparam int MEM_DEPTH = 4096;        // cells held in the single block memory
  localparam int NB_W = 8;                // width of block counts
  localparam int OUT_FIFO_DEPTH = 4000;   // overflow fifo beside the de-interleaver
  localparam int OUT_FIFO_SLACK = 1;      // one read is in flight when ready is sampled
  localparam int IN_BUF_DEPTH = 2;        // skid buffer on the input
  localparam int IN_BUF_SLACK = 0;
  localparam logic [SW-1:0] COLS_PER_FEC = 13'h0005;  // columns used by one fec block
  localparam logic [SW-1:0] K_INIT = 13'h0001;        // increment of the first block
  localparam logic [SW-1:0] ADDR_ZERO = 13'h0000;     // address at each block start
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FILL = 2'b01,
    ST_RUN = 2'b11
  } tdi_state_t;
endpackage : tdi_pkg

// >>> rtl/tdi_fifo.sv
// first-word-registered fifo with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module tdi_fifo #(
  parameter int W = 24,
  parameter int DEPTH = 2,
  parameter int SLACK = 0
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic in_valid_in,
  input wire logic [W-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [W-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int PW = (DEPTH > 2) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW:0] LIMIT = (CW + 1)'(DEPTH - SLACK);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [W-1:0] head_q, head_d;
  logic hv_q, hv_d, rdy_q, rdy_d;
  logic push, pop, wr_mem;
  logic [CW:0] total_d;
  logic [CW:0] occ;

  // next state; the head register keeps the output straight from a flop
  always_comb begin
    occ = {1'b0, cnt_q} + (CW + 1)'(hv_q);
    // with slack, a word launched while ready was high still lands if a place is free
    push = in_valid_in && (rdy_q || (SLACK > 0 && occ < (CW + 1)'(DEPTH)));
    pop = hv_q && out_ready_in;
    wp_d = wp_q;
    rp_d = rp_q;
    cnt_d = cnt_q;
    head_d = head_q;
    hv_d = hv_q;
    wr_mem = 1'b0;
    if (cnt_q == '0 && push && (!hv_q || pop)) begin
      head_d = in_data_in;   // bypass straight into the head
      hv_d = 1'b1;
    end else begin
      if (pop) begin
        hv_d = (cnt_q != '0);
        if (cnt_q != '0) begin
          head_d = mem[rp_q];
          rp_d = (rp_q == LAST) ? '0 : rp_q + 1'b1;
        end
      end
      if (push) begin
        wr_mem = 1'b1;
        wp_d = (wp_q == LAST) ? '0 : wp_q + 1'b1;
      end
      cnt_d = cnt_q + CW'(push) - CW'(pop && cnt_q != '0);
    end
    total_d = {1'b0, cnt_d} + (CW + 1)'(hv_d);
    // ready is registered, so it must already cover what arrives next cycle
    rdy_d = total_d < LIMIT;
  end

  // state registers
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      head_q <= '0;
      hv_q <= 1'b0;
      rdy_q <= 1'b0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      head_q <= head_d;
      hv_q <= hv_d;
      rdy_q <= rdy_d;
    end
  end

  // storage has no reset, only the pointers, count, head and flags do
  always_ff @(posedge clk_in) begin
    if (wr_mem) begin
      mem[wp_q] <= in_data_in;
    end
  end

  assign in_ready_out = rdy_q;
  assign out_valid_out = hv_q;
  assign out_data_out = head_q;

  a_fifo_no_overflow: assert property (@(posedge clk_in) disable iff (!rstn_in)
    ({1'b0, cnt_q} + (CW + 1)'(hv_q)) <= (CW + 1)'(DEPTH))
    else $error("fifo holds more words than its depth");
endmodule : tdi_fifo
`default_nettype wire

// >>> rtl/tdi_deinterleaver.sv
// single-memory time de-interleaver with address generator and overflow fifo
`timescale 1ns/100ps
`default_nettype none
module tdi_deinterleaver (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic cfg_load_in,
  input wire logic cfg_ti_enable_in,
  input wire logic [tdi_pkg::SW-1:0] cfg_cols_in,
  input wire logic [tdi_pkg::SW-1:0] cfg_mem_size_in,
  input wire logic [tdi_pkg::SW-1:0] cfg_cells_per_fec_in,
  input wire logic [tdi_pkg::NB_W-1:0] configured_max_block_count_in,
  input wire logic [tdi_pkg::NB_W-1:0] ti_blocks_per_interleaving_frame_in,
  input wire logic [tdi_pkg::NB_W-1:0] blocks_written_in,
  input wire logic in_valid_in,
  input wire logic [tdi_pkg::CELL_W-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [tdi_pkg::CELL_W-1:0] out_data_out,
  input wire logic out_ready_in,
  output logic busy_out,
  output logic [tdi_pkg::SW-1:0] incr_out
);
  import tdi_pkg::*;

  tdi_state_t st_q, st_d;
  logic [SW-1:0] cols_q, cols_d, msize_q, msize_d, cpf_q, cpf_d;
  logic [NB_W-1:0] nmax_q, nmax_d, miss_q, miss_d;
  logic ten_q, ten_d;
  logic [SW-1:0] k_q, k_d, kcap_q, kcap_d, wa_q, wa_d, ra_q, ra_d;
  logic [SW-1:0] wr_pos_q, wr_pos_d, rd_pos_q, rd_pos_d, wr_col_q, wr_col_d;
  logic [SW+NB_W-1:0] roff_q, roff_d;
  logic busy_q, busy_d;
  logic rd_v_q;
  logic [CELL_W-1:0] rd_data_q;
  logic [CELL_W-1:0] mem [MEM_DEPTH];
  logic ib_v, ib_rdy, of_rdy;
  logic [CELL_W-1:0] ib_data;
  logic wr_done, rd_done, wr_skip, rd_skip, wr_ok, wr_step, wr_go, rd_step, rd_go, blk_end;
  logic [NB_W-1:0] nmax_new, nwr_now;
  logic [SW+NB_W-1:0] skip_len;

  // one address step: modulo-M sum with the extra unit on wrap
  function automatic logic [SW-1:0] tdi_step(input logic [SW-1:0] a, input logic [SW-1:0] k,
                                             input logic [SW-1:0] m);
    logic [SW:0] s;
    s = {1'b0, a} + {1'b0, k};
    if (s >= {1'b0, m}) begin
      s = s - {1'b0, m} + (SW + 1)'(1);
    end
    return s[SW-1:0];
  endfunction : tdi_step

  // input skid buffer: a stalled write loses no cell
  tdi_fifo #(.W(CELL_W), .DEPTH(IN_BUF_DEPTH), .SLACK(IN_BUF_SLACK)) u_in_buf (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .in_valid_in(in_valid_in),
    .in_data_in(in_data_in),
    .in_ready_out(in_ready_out),
    .out_valid_out(ib_v),
    .out_data_out(ib_data),
    .out_ready_in(ib_rdy)
  );

  // overflow fifo after the memory absorbs decoder stalls
  tdi_fifo #(.W(CELL_W), .DEPTH(OUT_FIFO_DEPTH), .SLACK(OUT_FIFO_SLACK)) u_out_fifo (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .in_valid_in(rd_v_q),
    .in_data_in(rd_data_q),
    .in_ready_out(of_rdy),
    .out_valid_out(out_valid_out),
    .out_data_out(out_data_out),
    .out_ready_in(out_ready_in)
  );

  // access decisions for this cycle
  always_comb begin
    nwr_now = (blocks_written_in > nmax_q) ? nmax_q : blocks_written_in;
    nmax_new = (ti_blocks_per_interleaving_frame_in == '0) ? configured_max_block_count_in :
               configured_max_block_count_in / ti_blocks_per_interleaving_frame_in;
    skip_len = (SW + NB_W)'(miss_q) * (SW + NB_W)'(COLS_PER_FEC);
    wr_done = (wr_pos_q == msize_q);
    rd_done = (st_q != ST_RUN) || (rd_pos_q == msize_q);
    wr_skip = (SW + NB_W)'(wr_col_q) < skip_len;
    rd_skip = (SW + NB_W)'(rd_pos_q) < roff_q;
    // reads only skip the head start, never inside the sequence
    rd_step = (st_q == ST_RUN) && !rd_done && (rd_skip || of_rdy);
    rd_go = rd_step && !rd_skip;
    // a write may only land where the old cell is gone or goes this cycle
    wr_ok = (wr_pos_q < rd_pos_q) || ((wr_pos_q == rd_pos_q) && rd_step) || rd_done;
    wr_step = (st_q != ST_IDLE) && !wr_done && wr_ok && (wr_skip || ib_v);
    wr_go = wr_step && !wr_skip;
    ib_rdy = wr_go;
    blk_end = (st_q != ST_IDLE) && wr_done && rd_done;
  end

  // next values of the address generators and block control
  always_comb begin
    st_d = st_q;
    cols_d = cols_q;
    msize_d = msize_q;
    cpf_d = cpf_q;
    nmax_d = nmax_q;
    ten_d = ten_q;
    miss_d = miss_q;
    k_d = k_q;
    kcap_d = kcap_q;
    wa_d = wa_q;
    ra_d = ra_q;
    wr_pos_d = wr_pos_q;
    rd_pos_d = rd_pos_q;
    wr_col_d = wr_col_q;
    roff_d = roff_q;
    unique case (st_q)
      ST_IDLE: begin
        // configuration is taken only here and frozen afterwards
        if (cfg_load_in) begin
          cols_d = cfg_cols_in;
          msize_d = cfg_mem_size_in;
          cpf_d = cfg_cells_per_fec_in;
          ten_d = cfg_ti_enable_in;
          nmax_d = nmax_new;
          miss_d = nmax_new - ((blocks_written_in > nmax_new) ? nmax_new : blocks_written_in);
          k_d = K_INIT;
          wa_d = ADDR_ZERO;
          ra_d = ADDR_ZERO;
          wr_pos_d = '0;
          rd_pos_d = '0;
          wr_col_d = '0;
          roff_d = '0;
          st_d = ST_FILL;
        end
      end
      ST_FILL, ST_RUN: begin
        if (blk_end) begin
          wa_d = ADDR_ZERO;
          ra_d = ADDR_ZERO;
          wr_pos_d = '0;
          rd_pos_d = '0;
          wr_col_d = '0;
          // a captured increment of one is the sequential start state again
          k_d = ten_q ? kcap_q : K_INIT;
          roff_d = (SW + NB_W)'(cpf_q) * (SW + NB_W)'(miss_q);
          miss_d = nmax_q - nwr_now;
          st_d = ST_RUN;
        end else begin
          if (wr_step) begin
            if (wr_pos_q == cols_q) begin
              kcap_d = wa_q;
            end
            wa_d = tdi_step(wa_q, k_q, msize_q);
            wr_pos_d = wr_pos_q + 1'b1;
            wr_col_d = (wr_col_q == cols_q - 1'b1) ? '0 : wr_col_q + 1'b1;
          end
          if (rd_step) begin
            ra_d = tdi_step(ra_q, k_q, msize_q);
            rd_pos_d = rd_pos_q + 1'b1;
          end
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
    busy_d = (st_d != ST_IDLE);
  end

  // state registers
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q <= ST_IDLE;
      cols_q <= '0;
      msize_q <= '0;
      cpf_q <= '0;
      nmax_q <= '0;
      ten_q <= 1'b0;
      miss_q <= '0;
      k_q <= K_INIT;
      kcap_q <= K_INIT;
      wa_q <= ADDR_ZERO;
      ra_q <= ADDR_ZERO;
      wr_pos_q <= '0;
      rd_pos_q <= '0;
      wr_col_q <= '0;
      roff_q <= '0;
      busy_q <= 1'b0;
      rd_v_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cols_q <= cols_d;
      msize_q <= msize_d;
      cpf_q <= cpf_d;
      nmax_q <= nmax_d;
      ten_q <= ten_d;
      miss_q <= miss_d;
      k_q <= k_d;
      kcap_q <= kcap_d;
      wa_q <= wa_d;
      ra_q <= ra_d;
      wr_pos_q <= wr_pos_d;
      rd_pos_q <= rd_pos_d;
      wr_col_q <= wr_col_d;
      roff_q <= roff_d;
      busy_q <= busy_d;
      rd_v_q <= rd_go;
    end
  end

  // block memory: read-before-write so the cell just read is replaced in place
  always_ff @(posedge clk_in) begin
    if (rd_go) begin
      rd_data_q <= mem[ra_q[AW-1:0]];
    end
    if (wr_go) begin
      mem[wa_q[AW-1:0]] <= ib_data;
    end
  end

  assign busy_out = busy_q;
  assign incr_out = k_q;

  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  logic [SW:0] wsum;
  assign wsum = {1'b0, wa_q} + {1'b0, k_q};

  sequence s_capture;
    wr_step && (wr_pos_q == cols_q) && !blk_end;
  endsequence

  sequence s_next_block;
    blk_end && ten_q;
  endsequence

  a_block_start_zero: assert property (blk_end |=> (wa_q == ADDR_ZERO) && (ra_q == ADDR_ZERO))
    else $error("addresses not zero at block start");
  a_addr_no_wrap: assert property ((wr_step && !blk_end && wsum < {1'b0, msize_q})
    |=> wa_q == $past(wsum[SW-1:0]))
    else $error("write address step without wrap is wrong");
  a_addr_wrap: assert property ((wr_step && !blk_end && wsum >= {1'b0, msize_q})
    |=> {1'b0, wa_q} == $past(wsum) - {1'b0, $past(msize_q)} + (SW + 1)'(1))
    else $error("write address wrap lacks the extra unit");
  a_incr_capture: assert property (s_capture |=> kcap_q == $past(wa_q))
    else $error("increment not captured at position c");
  a_incr_apply: assert property (s_next_block |=> k_q == $past(kcap_q))
    else $error("captured increment not used in next block");
  a_skip_no_write: assert property (wr_step && wr_skip |-> !ib_rdy)
    else $error("a skipped write position consumed a cell");
  a_read_head_start: assert property (rd_go |-> (SW + NB_W)'(rd_pos_q) >= roff_q)
    else $error("read issued inside the head start");
  a_disabled_seq: assert property ((!ten_q && st_q == ST_RUN) |-> k_q == K_INIT)
    else $error("disabled mode not sequential");
  a_inplace_write: assert property ((wr_go && rd_go && wr_pos_q == rd_pos_q) |-> wa_q == ra_q)
    else $error("write not at the address just read");
  a_fill_silent: assert property (st_q == ST_FILL |=> !rd_v_q)
    else $error("output produced during first fill");
  a_cfg_frozen: assert property (st_q != ST_IDLE |=> $stable(cols_q) && $stable(msize_q))
    else $error("configuration changed while running");
endmodule : tdi_deinterleaver
`default_nettype wire

// >>> dv/tdi_stream_partner.sv
// cell source ahead of the de-interleaver and fec-side sink behind it
`timescale 1ns/100ps
`default_nettype none
module tdi_stream_partner #(
  parameter int ROWS = 4,
  parameter int COLS = 10,
  parameter int NMAX = 2,
  parameter int NBLK = 8
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic go_in,
  input wire logic hold_in,
  input wire logic [7:0] mask_in,
  input wire logic in_ready_in,
  output logic in_valid_out,
  output logic [tdi_pkg::CELL_W-1:0] in_data_out,
  output logic [tdi_pkg::NB_W-1:0] blocks_written_out,
  output logic out_ready_out
);
  import tdi_pkg::*;
  int blk;
  int idx;
  logic took;
  // a set mask bit makes a half block; full blocks claim one too many so the clip is exercised
  function automatic int nwr_of(input int b);
    return mask_in[b % 8] ? 1 : NMAX;
  endfunction : nwr_of
  assign blocks_written_out = mask_in[blk % 8] ? 8'h01 : NB_W'(NMAX + 1);
  // remember whether the held cell went in at the last rising edge
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) took <= 1'b0;
    else took <= in_valid_out && in_ready_in;
  end
  // one block never exceeds the memory, so only one block is written while one is read
  always @(negedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      blk = 0;
      idx = 0;
      in_valid_out <= 1'b0;
      in_data_out <= '0;
      out_ready_out <= 1'b0;
    end else begin
      out_ready_out <= !hold_in && ($urandom % 4 != 0);
      if (took) begin
        idx++;
        if (idx == ROWS * (COLS - 5 * (NMAX - nwr_of(blk)))) begin
          blk++;
          idx = 0;
        end
      end
      if (go_in && blk < NBLK) begin
        if (took || !in_valid_out) in_data_out <= CELL_W'($urandom);
        in_valid_out <= 1'b1;
      end else begin
        // released data line is inverted each cycle, so the stale word returns every second cycle
        in_valid_out <= 1'b0;
        in_data_out <= ~in_data_out;
      end
    end
  end
endmodule : tdi_stream_partner
`default_nettype wire

// >>> dv/tb_top.sv
// self-checking bench for the time de-interleaver with a cell-order model
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import tdi_pkg::*;
  localparam int ROWS = 4;
  localparam int COLS = 10;
  localparam int MSZ = ROWS * COLS;
  localparam int NMAX = 2; // five blocks over two frames, rounded down
  localparam int NCELL = 20;
  localparam int NBLK = 8;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic cfg_load = 1'b0;
  logic ti_en = 1'b1;
  logic go = 1'b0;
  logic hold = 1'b0;
  logic [7:0] mask = 8'h00;
  logic in_valid, in_ready, out_valid, out_ready, busy;
  logic [CELL_W-1:0] in_data, out_data;
  logic [SW-1:0] incr;
  logic [NB_W-1:0] bw;
  int error_cnt = 0;
  int samples_checked = 0;
  int mem[MSZ];
  int expq[$];
  int k, cap, a, pos, hs, blk, nin, first, nwr;

  always #2 clk_in = ~clk_in;

  tdi_deinterleaver u_dut (.clk_in(clk_in), .rstn_in(rstn_in), .cfg_load_in(cfg_load),
    .cfg_ti_enable_in(ti_en), .cfg_cols_in(SW'(COLS)), .cfg_mem_size_in(SW'(MSZ)),
    .cfg_cells_per_fec_in(SW'(NCELL)), .configured_max_block_count_in(8'h05),
    .ti_blocks_per_interleaving_frame_in(8'h02), .blocks_written_in(bw),
    .in_valid_in(in_valid), .in_data_in(in_data), .in_ready_out(in_ready),
    .out_valid_out(out_valid), .out_data_out(out_data), .out_ready_in(out_ready),
    .busy_out(busy), .incr_out(incr));

  tdi_stream_partner #(.ROWS(ROWS), .COLS(COLS), .NMAX(NMAX), .NBLK(NBLK)) u_partner (
    .clk_in(clk_in), .rstn_in(rstn_in), .go_in(go), .hold_in(hold), .mask_in(mask),
    .in_ready_in(in_ready), .in_valid_out(in_valid), .in_data_out(in_data),
    .blocks_written_out(bw), .out_ready_out(out_ready));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR time=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done();
    $display("comparisons=%0d mismatches=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  function automatic int nwr_of(input int b);
    return mask[b % 8] ? 1 : NMAX;
  endfunction : nwr_of

  task automatic model_reset();
    a = 0;
    pos = 0;
    k = 1;
    cap = 1;
    blk = 0;
    nin = 0;
    first = 1;
    hs = 0;
    nwr = nwr_of(0);
    expq.delete();
    foreach (mem[i]) mem[i] = 0;
  endtask : model_reset

  // one generated address: old cell out, new cell into the same place
  task automatic model_step(input bit wr, input int d);
    if (wr) mem[a] = d;
    if (pos == COLS) cap = a;
    a = (a + k >= MSZ) ? a + k - (MSZ - 1) : a + k;
    pos++;
  endtask : model_step

  task automatic model_cell(input int d);
    int aa;
    while ((pos % COLS) < 5 * (NMAX - nwr)) model_step(1'b0, 0);
    model_step(1'b1, d);
    nin++;
    if (pos == MSZ) begin
      hs = NCELL * (NMAX - nwr);
      k = ti_en ? cap : 1;
      a = 0;
      pos = 0;
      first = 0;
      blk++;
      nin = 0;
      nwr = nwr_of(blk);
      // reads run ahead of writes, so the whole read order is queued at block end
      aa = 0;
      for (int p = 0; p < MSZ; p++) begin
        if (p >= hs) expq.push_back(mem[aa]);
        aa = (aa + k >= MSZ) ? aa + k - (MSZ - 1) : aa + k;
      end
    end
  endtask : model_cell

  // handshakes are judged on the values present just before each rising edge
  always @(posedge clk_in) begin
    if (rstn_in) begin
      if (first) check(out_valid, 32'h0);
      if (in_valid && in_ready) begin
        if (nin == 3) check(incr, k);
        model_cell(in_data);
      end
      if (out_valid && out_ready) begin
        if (expq.size() == 0) check(32'h1, 32'h0);
        else check(out_data, expq.pop_front());
      end
    end
  end

  task automatic run(input logic en, input logic [7:0] m);
    int n;
    @(negedge clk_in);
    rstn_in = 1'b0;
    go = 1'b0;
    ti_en = en;
    mask = m;
    repeat (10) @(negedge clk_in);
    check(incr, 32'h1);
    check(out_valid, 32'h0);
    check(busy, 32'h0);
    model_reset();
    rstn_in = 1'b1;
    @(negedge clk_in);
    cfg_load = 1'b1;
    @(negedge clk_in);
    cfg_load = 1'b0;
    go = 1'b1;
    @(negedge clk_in);
    check(busy, 32'h1);
    // a long sink stall in mid-run must lose no cell
    n = 0;
    while ((blk < NBLK || expq.size() != 0) && n < 8000) begin
      hold = (n >= 100 && n < 300);
      @(negedge clk_in);
      n++;
    end
    hold = 1'b0;
    repeat (30) @(negedge clk_in);
    check(blk, NBLK);
    check(expq.size(), 32'h0);
  endtask : run

  initial begin
    void'($urandom(32'hCAC0));
    run(1'b1, 8'h14);
    run(1'b0, 8'h00);
    test_done();
  end

  // watchdog well beyond two runs of eight blocks each
  initial begin
    #120000;
    error_cnt++;
    $display("ERROR time=%0t watchdog expired", $time);
    test_done();
  end
endmodule : tb_top
`default_nettype wire
